// file: verilog/fsp_pkg.sv
// shared constants for the flash sector protection block
package fsp_pkg;
  // ---------------------------------------------------------------
  // command opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] FSP_OP_WR_ENABLE = 8'h06;
  localparam logic [7:0] FSP_OP_WR_DISABLE = 8'h04;
  localparam logic [7:0] FSP_OP_PROTECT = 8'h36;
  localparam logic [7:0] FSP_OP_UNPROTECT = 8'h39;
  localparam logic [7:0] FSP_OP_STATUS_WR = 8'h01;
  // ---------------------------------------------------------------
  // status write data fields
  // ---------------------------------------------------------------
  localparam int FSP_SR_LOCK_BIT = 7;
  localparam int FSP_SR_PAT_HI = 5;
  localparam int FSP_SR_PAT_LO = 2;
  localparam logic [3:0] FSP_PAT_ALL_ONE = 4'hF;
  localparam logic [3:0] FSP_PAT_ALL_ZERO = 4'h0;
  // ---------------------------------------------------------------
  // frame geometry and reset values
  // ---------------------------------------------------------------
  localparam int FSP_ADDR_W = 24;
  localparam logic [2:0] FSP_BYTES_SECT = 3'h4;
  localparam logic [2:0] FSP_BYTES_SR = 3'h2;
  localparam logic [2:0] FSP_BYTES_MAX = 3'h4;
  localparam logic [2:0] FSP_BIT_LAST = 3'h7;
  localparam logic FSP_FLAG_RESET = 1'b1;
  localparam logic FSP_LATCH_RESET = 1'b0;
  localparam logic FSP_LOCK_RESET = 1'b0;
endpackage

// file: verilog/fsp_sector_protect.sv
// sector protection flags, write-permit latch and map lock behind a serial command port
// Functional notes
// [R01] one protection flag per physical sector
// [R02] reset sets every protection flag to one
// [R03] flag zero permits program/erase; one blocks
// [R04] protect needs write-permit latch set
// [R05] host sends 36h plus three address bytes
// [R06] valid protect sets addressed flag, clears latch
// [R07] short or misaligned frame aborts, clears latch
// [R08] lock set: protect ignored, latch cleared
// [R09] unprotect needs write-permit latch set
// [R10] host sends 39h plus three address bytes
// [R11] valid unprotect clears addressed flag, clears latch
// [R12] lock set: unprotect ignored, latch cleared
// [R13] status bits 5..2 ones protect all
// [R14] status bits 5..2 zeros unprotect all
// [R15] status write also updates map lock
// [R16] global and sector commands share flags
// [R17] unlocked: 00h clear, 7Fh set, FFh set+lock
// [R18] locked, guard high: only lock clearable
// [R19] locked, guard low: nothing changes; code still clears the latch
// [R20] sector index from upper address bits
module fsp_sector_protect #(
  parameter int NUM_SECT = 8,
  parameter int SECT_SHIFT = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // serial command pins
  input wire logic cs_b,
  input wire logic sck,
  input wire logic mosi,
  input wire logic write_guard_b,
  // program/erase permission query
  input wire logic [fsp_pkg::FSP_ADDR_W-1:0] check_addr,
  output logic sector_writable,
  // state
  output logic [NUM_SECT-1:0] prot_flags,
  output logic write_permit_latch,
  output logic protect_map_lock
);
  import fsp_pkg::*;

  localparam int IDX_W = (NUM_SECT > 1) ? $clog2(NUM_SECT) : 1;

  function automatic logic [IDX_W-1:0] sect_idx(input logic [FSP_ADDR_W-1:0] a);
    sect_idx = a[SECT_SHIFT +: IDX_W]; // R20
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] cs_sync_r, sck_sync_r, mosi_sync_r, wp_sync_r;
  logic cs_d_r, sck_d_r;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cs_sync_r <= 2'h3;
      sck_sync_r <= 2'h0;
      mosi_sync_r <= 2'h0;
      wp_sync_r <= 2'h3;
      cs_d_r <= 1'b1;
      sck_d_r <= 1'b0;
    end else begin
      cs_sync_r <= {cs_sync_r[0], cs_b};
      sck_sync_r <= {sck_sync_r[0], sck};
      mosi_sync_r <= {mosi_sync_r[0], mosi};
      wp_sync_r <= {wp_sync_r[0], write_guard_b};
      cs_d_r <= cs_sync_r[1];
      sck_d_r <= sck_sync_r[1];
    end
  end

  logic cs_low, sck_rise, frame_end, mosi_s, wp_high;
  assign cs_low = !cs_sync_r[1];
  assign sck_rise = cs_low && sck_sync_r[1] && !sck_d_r;
  assign frame_end = cs_sync_r[1] && !cs_d_r;
  assign mosi_s = mosi_sync_r[1];
  assign wp_high = wp_sync_r[1];

  // ---------------------------------------------------------------
  // frame capture
  // ---------------------------------------------------------------
  logic [6:0] shift_r;
  logic [2:0] bit_cnt_r, byte_cnt_r;
  logic [7:0] op_r, sr_data_r;
  logic [FSP_ADDR_W-1:0] addr_r;
  logic [7:0] byte_in;
  assign byte_in = {shift_r, mosi_s};

  always_ff @(posedge clk) begin
    if (!rst_b || !cs_low) begin
      shift_r <= 7'h00;
      bit_cnt_r <= 3'h0;
    end else if (sck_rise) begin
      shift_r <= byte_in[6:0];
      bit_cnt_r <= bit_cnt_r + 3'h1;
    end
  end

  // bytes past the address are counted no further, so trailing data is ignored
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      byte_cnt_r <= 3'h0;
      op_r <= 8'h00;
      sr_data_r <= 8'h00;
      addr_r <= '0;
    end else if (!cs_low && !frame_end) begin
      byte_cnt_r <= 3'h0;
    end else if (sck_rise && bit_cnt_r == FSP_BIT_LAST && byte_cnt_r != FSP_BYTES_MAX) begin
      byte_cnt_r <= byte_cnt_r + 3'h1;
      unique case (byte_cnt_r)
        3'h0: op_r <= byte_in;
        3'h1: begin
          addr_r[23:16] <= byte_in; // R05 R10
          sr_data_r <= byte_in;
        end
        3'h2: addr_r[15:8] <= byte_in;
        default: addr_r[7:0] <= byte_in;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // frame decision at chip-select release
  // ---------------------------------------------------------------
  logic has_op, aligned, is_sect, sect_full, sect_ok, sr_ok;
  logic do_prot, do_unprot, do_gprot, do_gunprot, lock_we, lock_nxt;
  logic [3:0] pattern;

  assign has_op = frame_end && byte_cnt_r != 3'h0;
  assign aligned = bit_cnt_r == 3'h0;
  assign is_sect = op_r == FSP_OP_PROTECT || op_r == FSP_OP_UNPROTECT;
  assign sect_full = byte_cnt_r >= FSP_BYTES_SECT;
  // lock and latch both gate the sector commands
  assign sect_ok = has_op && is_sect && aligned && sect_full && write_permit_latch
    && !protect_map_lock; // R04 R07 R08 R09 R12
  assign do_prot = sect_ok && op_r == FSP_OP_PROTECT; // R06
  assign do_unprot = sect_ok && op_r == FSP_OP_UNPROTECT; // R11
  assign sr_ok = has_op && op_r == FSP_OP_STATUS_WR && aligned
    && byte_cnt_r >= FSP_BYTES_SR && write_permit_latch;
  assign pattern = sr_data_r[FSP_SR_PAT_HI:FSP_SR_PAT_LO];
  assign do_gprot = sr_ok && !protect_map_lock && pattern == FSP_PAT_ALL_ONE; // R13 R17
  assign do_gunprot = sr_ok && !protect_map_lock && pattern == FSP_PAT_ALL_ZERO; // R14 R17
  // hard lock when guard low; soft lock only lets the lock itself move
  assign lock_we = sr_ok && (!protect_map_lock || wp_high); // R15 R18 R19
  assign lock_nxt = sr_data_r[FSP_SR_LOCK_BIT];

  // ---------------------------------------------------------------
  // state registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      write_permit_latch <= FSP_LATCH_RESET;
    end else if (has_op && aligned && op_r == FSP_OP_WR_ENABLE) begin
      write_permit_latch <= 1'b1;
    end else if (has_op && aligned && op_r == FSP_OP_WR_DISABLE) begin
      write_permit_latch <= 1'b0;
    end else if (has_op && (is_sect || op_r == FSP_OP_STATUS_WR)) begin
      write_permit_latch <= 1'b0; // R06 R07 R08 R11 R12
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      protect_map_lock <= FSP_LOCK_RESET;
    end else if (lock_we) begin
      protect_map_lock <= lock_nxt; // R15 R17 R18
    end
  end

  // one flop array serves both global and per-sector updates
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      prot_flags <= {NUM_SECT{FSP_FLAG_RESET}}; // R01 R02
    end else if (do_gprot) begin
      prot_flags <= '1; // R13 R16
    end else if (do_gunprot) begin
      prot_flags <= '0; // R14 R16
    end else if (do_prot) begin
      prot_flags[sect_idx(addr_r)] <= 1'b1; // R06 R16
    end else if (do_unprot) begin
      prot_flags[sect_idx(addr_r)] <= 1'b0; // R11 R16
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sector_writable <= 1'b0;
    end else begin
      sector_writable <= !prot_flags[sect_idx(check_addr)]; // R03
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_reset_all_set: assert property (@(posedge clk) // R02
    $rose(rst_b) |-> prot_flags == {NUM_SECT{1'b1}} && !protect_map_lock)
    else $error("flags not all set after reset");

  // addr_r holds once chip select is high, so the index needs no history
  a_prot_sets_flag: assert property (@(posedge clk) disable iff (!rst_b) // R06
    do_prot |=> prot_flags[sect_idx(addr_r)] && !write_permit_latch)
    else $error("protect did not set flag or clear latch");

  a_unprot_clears: assert property (@(posedge clk) disable iff (!rst_b) // R11
    do_unprot |=> !prot_flags[sect_idx(addr_r)] && !write_permit_latch)
    else $error("unprotect did not clear flag or latch");

  a_abort_no_change: assert property (@(posedge clk) disable iff (!rst_b) // R07
    has_op && is_sect && (!aligned || !sect_full) |=> $stable(prot_flags) && !write_permit_latch)
    else $error("aborted sector frame changed state");

  a_lock_ignores: assert property (@(posedge clk) disable iff (!rst_b) // R08
    has_op && is_sect && protect_map_lock |=> $stable(prot_flags) && !write_permit_latch)
    else $error("sector command acted while map locked");

  a_latch_needed: assert property (@(posedge clk) disable iff (!rst_b) // R04
    frame_end && !write_permit_latch |=> $stable(prot_flags))
    else $error("flags changed without write permit");

  a_hard_lock: assert property (@(posedge clk) disable iff (!rst_b) // R19
    frame_end && protect_map_lock && !wp_high |=> $stable(prot_flags) && protect_map_lock)
    else $error("hard lock did not hold");

  a_soft_unlock: assert property (@(posedge clk) disable iff (!rst_b) // R18
    sr_ok && protect_map_lock && wp_high && !lock_nxt |=> !protect_map_lock && $stable(prot_flags))
    else $error("soft lock not cleared or flags moved");

  a_global_patterns: assert property (@(posedge clk) disable iff (!rst_b) // R17
    sr_ok && !protect_map_lock && sr_data_r == 8'hFF
      |=> prot_flags == {NUM_SECT{1'b1}} && protect_map_lock)
    else $error("FFh write did not protect and lock");

  a_global_clear: assert property (@(posedge clk) disable iff (!rst_b) // R14
    do_gunprot |=> prot_flags == '0 ##1 sector_writable)
    else $error("global unprotect failed");

  // enable and disable frames move the latch only when complete and aligned
  a_wren_sets_latch: assert property (@(posedge clk) disable iff (!rst_b) // R04 R09
    has_op && aligned && op_r == FSP_OP_WR_ENABLE |=> write_permit_latch)
    else $error("write enable did not set latch");

  a_wrdis_clears: assert property (@(posedge clk) disable iff (!rst_b) // R04
    has_op && aligned && op_r == FSP_OP_WR_DISABLE |=> !write_permit_latch)
    else $error("write disable did not clear latch");

  a_misalign_wren: assert property (@(posedge clk) disable iff (!rst_b) // R04
    has_op && !aligned && (op_r == FSP_OP_WR_ENABLE || op_r == FSP_OP_WR_DISABLE)
      |=> $stable(write_permit_latch))
    else $error("misaligned enable frame moved latch");

  a_unlatched_sect: assert property (@(posedge clk) disable iff (!rst_b) // R09
    has_op && is_sect && !write_permit_latch |=> $stable(prot_flags))
    else $error("sector command acted without write permit");

  a_sect_clears_latch: assert property (@(posedge clk) disable iff (!rst_b) // R06 R11
    has_op && is_sect |=> !write_permit_latch)
    else $error("sector frame left latch set");

  a_blocked_when_set: assert property (@(posedge clk) disable iff (!rst_b) // R03
    prot_flags == {NUM_SECT{1'b1}} |=> !sector_writable)
    else $error("protected sector reported writable");

  a_open_when_clear: assert property (@(posedge clk) disable iff (!rst_b) // R03
    prot_flags == {NUM_SECT{1'b0}} |=> sector_writable)
    else $error("unprotected sector reported blocked");

  a_one_sector_only: assert property (@(posedge clk) disable iff (!rst_b) // R01 R16
    do_prot || do_unprot |=> $countones(prot_flags ^ $past(prot_flags)) <= 1)
    else $error("sector command touched more than one flag");

  a_gprot_all_set: assert property (@(posedge clk) disable iff (!rst_b) // R13
    do_gprot |=> prot_flags == {NUM_SECT{1'b1}})
    else $error("global protect left a flag clear");

  a_lock_follows: assert property (@(posedge clk) disable iff (!rst_b) // R15
    lock_we |=> protect_map_lock == $past(lock_nxt))
    else $error("map lock did not follow status data");

  a_sr_needs_latch: assert property (@(posedge clk) disable iff (!rst_b) // R15
    has_op && op_r == FSP_OP_STATUS_WR && !write_permit_latch
      |=> $stable(prot_flags) && $stable(protect_map_lock))
    else $error("status write acted without write permit");

  a_soft_no_global: assert property (@(posedge clk) disable iff (!rst_b) // R18
    sr_ok && protect_map_lock && wp_high |=> $stable(prot_flags))
    else $error("soft lock let a global update through");

  a_keep_unlocked: assert property (@(posedge clk) disable iff (!rst_b) // R17
    sr_ok && !protect_map_lock && sr_data_r == 8'h7F
      |=> prot_flags == {NUM_SECT{1'b1}} && !protect_map_lock)
    else $error("7Fh write did not protect with lock clear");

  a_clear_unlocked: assert property (@(posedge clk) disable iff (!rst_b) // R17
    sr_ok && !protect_map_lock && sr_data_r == 8'h00
      |=> prot_flags == {NUM_SECT{1'b0}} && !protect_map_lock)
    else $error("00h write did not unprotect with lock clear");

  // state may only move at the chip-select release that ends a frame
  a_idle_hold: assert property (@(posedge clk) disable iff (!rst_b) // R16
    !frame_end |=> $stable(prot_flags) && $stable(protect_map_lock)
      && $stable(write_permit_latch))
    else $error("state moved outside a frame end");

  c_sector_protect: cover property (@(posedge clk) disable iff (!rst_b) do_prot);
  c_sector_unprotect: cover property (@(posedge clk) disable iff (!rst_b) do_unprot);
  c_global_lock: cover property (@(posedge clk) disable iff (!rst_b)
    do_gprot && lock_nxt);
  c_abort: cover property (@(posedge clk) disable iff (!rst_b)
    has_op && is_sect && !aligned);
  c_hard_lock: cover property (@(posedge clk) disable iff (!rst_b)
    frame_end && protect_map_lock && !wp_high);
endmodule

// file: test/fsp_host.sv
// host serial controller model that shifts command frames into the block
module fsp_host (
  // clock
  input wire logic clk,
  // serial pins
  output logic cs_b,
  output logic sck,
  output logic mosi
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cs_b = 1'b1;
    sck = 1'b0;
    mosi = 1'b0;
  end
  // ---------------------------------------------------------------
  // frame: nbits taken msb first from d; a short nbits gives an abort
  // ---------------------------------------------------------------
  task automatic frame(input logic [39:0] d, input int nbits);
    int i;
    @(posedge clk) cs_b <= 1'b0;
    for (i = 0; i < nbits; i++) begin
      @(posedge clk) mosi <= d[39-i];
      // phases of 4 clk keep clear of the synchroniser lag
      repeat (4) @(posedge clk);
      sck <= 1'b1;
      repeat (4) @(posedge clk);
      sck <= 1'b0;
    end
    repeat (4) @(posedge clk);
    cs_b <= 1'b1;
    // released line shows the inverse, never a stale bit
    mosi <= ~mosi;
    repeat (10) @(posedge clk);
  endtask
endmodule

// file: test/fsp_sector_protect_bench.sv
// self-checking bench for the sector protection block
module fsp_sector_protect_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import fsp_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic write_guard_b = 1'b1;
  logic [23:0] check_addr = 24'h000000;
  logic cs_b, sck, mosi, sector_writable, write_permit_latch, protect_map_lock;
  logic [7:0] prot_flags;
  int n_mismatch = 0;
  int samples_checked = 0;
  always #2.5 clk = ~clk;
  fsp_host host (.clk(clk), .cs_b(cs_b), .sck(sck), .mosi(mosi));
  fsp_sector_protect #(.NUM_SECT(8), .SECT_SHIFT(16)) uut (
    .clk(clk), .rst_b(rst_b), .cs_b(cs_b), .sck(sck), .mosi(mosi),
    .write_guard_b(write_guard_b), .check_addr(check_addr),
    .sector_writable(sector_writable), .prot_flags(prot_flags),
    .write_permit_latch(write_permit_latch), .protect_map_lock(protect_map_lock));
  // ---------------------------------------------------------------
  // compare and closing
  // ---------------------------------------------------------------
  task automatic chk_state(input logic [7:0] ef, input logic el, input logic ek);
    samples_checked++;
    if ({prot_flags, write_permit_latch, protect_map_lock} !== {ef, el, ek}) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time,
               {prot_flags, write_permit_latch, protect_map_lock}, {ef, el, ek});
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("mismatches=%0d compared=%0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wr_en;
    host.frame({FSP_OP_WR_ENABLE, 32'h0}, 8);
  endtask
  task automatic probe(input logic [23:0] a, input logic exp);
    @(posedge clk) check_addr <= a;
    repeat (3) @(posedge clk);
    chk_bit(sector_writable, exp);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    chk_state(8'hFF, 1'b0, 1'b0);
    probe(24'h050000, 1'b0);
  endtask
  task automatic t_sector;
    wr_en();
    chk_state(8'hFF, 1'b1, 1'b0);
    // trailing byte after the address must be ignored
    host.frame({FSP_OP_UNPROTECT, 24'h03ABCD, 8'h5A}, 40);
    chk_state(8'hF7, 1'b0, 1'b0);
    probe(24'h03FFFF, 1'b1);
    probe(24'h040000, 1'b0);
    host.frame({FSP_OP_UNPROTECT, 24'h060000, 8'h00}, 32);
    chk_state(8'hF7, 1'b0, 1'b0);
    wr_en();
    host.frame({FSP_OP_PROTECT, 24'h031000, 8'h00}, 32);
    chk_state(8'hFF, 1'b0, 1'b0);
  endtask
  task automatic t_abort;
    wr_en();
    host.frame({FSP_OP_UNPROTECT, 24'h020000, 8'h00}, 24);
    chk_state(8'hFF, 1'b0, 1'b0);
    wr_en();
    host.frame({FSP_OP_UNPROTECT, 24'h020000, 8'h00}, 29);
    chk_state(8'hFF, 1'b0, 1'b0);
  endtask
  task automatic t_global;
    // status write without the latch must be refused
    host.frame({FSP_OP_STATUS_WR, 8'h00, 24'h0}, 16);
    chk_state(8'hFF, 1'b0, 1'b0);
    wr_en();
    host.frame({FSP_OP_STATUS_WR, 8'h00, 24'h0}, 16);
    chk_state(8'h00, 1'b0, 1'b0);
    wr_en();
    host.frame({FSP_OP_PROTECT, 24'h05FFFF, 8'h00}, 32);
    chk_state(8'h20, 1'b0, 1'b0);
    wr_en();
    host.frame({FSP_OP_PROTECT, 24'h010000, 8'h00}, 31);
    chk_state(8'h20, 1'b0, 1'b0);
    wr_en();
    host.frame({FSP_OP_STATUS_WR, 8'h7F, 24'h0}, 16);
    chk_state(8'hFF, 1'b0, 1'b0);
    // one clear flag so that FFh visibly sets all flags
    wr_en();
    host.frame({FSP_OP_UNPROTECT, 24'h010000, 8'h00}, 32);
    chk_state(8'hFD, 1'b0, 1'b0);
    wr_en();
    host.frame({FSP_OP_STATUS_WR, 8'hFF, 24'h0}, 16);
    chk_state(8'hFF, 1'b0, 1'b1);
  endtask
  task automatic t_locked;
    wr_en();
    host.frame({FSP_OP_UNPROTECT, 24'h000000, 8'h00}, 32);
    chk_state(8'hFF, 1'b0, 1'b1);
    wr_en();
    host.frame({FSP_OP_STATUS_WR, 8'h00, 24'h0}, 16);
    chk_state(8'hFF, 1'b0, 1'b0);
    wr_en();
    host.frame({FSP_OP_UNPROTECT, 24'h070000, 8'h00}, 32);
    chk_state(8'h7F, 1'b0, 1'b0);
    // lock with a clear flag, pattern 0001 leaves flags alone
    wr_en();
    host.frame({FSP_OP_STATUS_WR, 8'h84, 24'h0}, 16);
    chk_state(8'h7F, 1'b0, 1'b1);
    wr_en();
    host.frame({FSP_OP_PROTECT, 24'h070000, 8'h00}, 32);
    chk_state(8'h7F, 1'b0, 1'b1);
    @(posedge clk) write_guard_b <= 1'b0;
    wr_en();
    host.frame({FSP_OP_STATUS_WR, 8'h00, 24'h0}, 16);
    chk_state(8'h7F, 1'b0, 1'b1);
    probe(24'h07ABCD, 1'b1);
  endtask
  task automatic t_midreset;
    wr_en();
    chk_bit(write_permit_latch, 1'b1);
    host.frame({FSP_OP_WR_DISABLE, 32'h0}, 8);
    chk_bit(write_permit_latch, 1'b0);
    // enable cut off a byte boundary must leave the latch alone
    host.frame({FSP_OP_WR_ENABLE, 32'h0}, 12);
    chk_bit(write_permit_latch, 1'b0);
    wr_en();
    @(posedge clk) rst_b <= 1'b0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
    chk_state(8'hFF, 1'b0, 1'b0);
    probe(24'h070000, 1'b0);
  endtask
  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
    t_reset();
    t_sector();
    t_abort();
    t_global();
    t_locked();
    t_midreset();
    stop_test();
  end
  initial begin
    #400000;
    n_mismatch++;
    stop_test();
  end
endmodule
